// file: hdl/osc_params.svh
// constants for the oscillator select control block
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
// register addresses (word index on the plain register port)
`define OSC_ADDR_CTRL 4'h0
`define OSC_ADDR_KEY 4'h1
`define OSC_ADDR_IRQ_STAT 4'h2
`define OSC_ADDR_IRQ_EN 4'h3
`define OSC_ADDR_IRQ_CLR 4'h4
// field positions in the control register
`define OSC_CUR_HI 14
`define OSC_CUR_LO 12
`define OSC_REQ_HI 10
`define OSC_REQ_LO 8
`define OSC_LOCK_BIT 7
`define OSC_PLL_LOCK_BIT 5
`define OSC_FAIL_BIT 3
`define OSC_SWEN_BIT 0
// unlock keys, written to the key register back to back
`define OSC_KEY1 16'h0055
`define OSC_KEY2 16'h00aa
// time one source change takes before it is reported
`define OSC_SWITCH_NS 64
`define OSC_CLK_NS 8
`define OSC_SWITCH_CYC ((`OSC_SWITCH_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
// interrupt status bits
`define OSC_IRQ_DONE 0
`define OSC_IRQ_FAIL 1
`define OSC_IRQ_REFUSED 2
`endif

// file: hdl/osc_pkg.sv
// types for the oscillator select control block
`default_nettype none
package osc_pkg;
  typedef enum logic [2:0] {
    OSC_SRC_FAST_RC = 3'h0,
    OSC_SRC_FAST_RC_PLL = 3'h1,
    OSC_SRC_PRI = 3'h2,
    OSC_SRC_PRI_PLL = 3'h3,
    OSC_SRC_RSVD = 3'h4,
    OSC_SRC_LOW_POWER_RC = 3'h5,
    OSC_SRC_BACKUP_RC = 3'h6,
    OSC_SRC_DIV_FAST_RC = 3'h7
  } osc_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } osc_bus_req_t;
endpackage : osc_pkg
`default_nettype wire

// file: hdl/osc_sync.sv
// two flip-flop synchroniser for level inputs from other domains
`default_nettype none
module osc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : osc_sync
`default_nettype wire

// file: hdl/osc_ctrl.sv
// oscillator select control register with unlock, switch sequencing and fail flag
// Functional notes
// RL1 - current source field bits 14:12, read only, shows the active source code
// RL2 - requested source field bits 10:8 writable, loaded from configuration at reset
// RL3 - code 100 in either field is treated as fast RC
// RL4 - lock bit 7 with monitor config bit set freezes clock configuration
// RL5 - bit 5 reports PLL lock, read only
// RL6 - control writes take effect only right after the two-key unlock sequence
// RL7 - direct switch between the two PLL sources is refused
// RL8 - fail flag bit 3 cleared only by software; writing 1 while the flag is clear raises fail trap
// RL9 - bits 15, 11, 6, 4, 2, 1 ignore writes and read zero
// RL10 - switch enable bit 0 starts a switch, hardware clears it when done
// RL11 - detected oscillator failure sets fail flag and raises the trap
`include "osc_params.svh"
`default_nettype none
module osc_ctrl #(
  parameter logic [15:0] SWITCH_CYC = 16'(`OSC_SWITCH_CYC)
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [2:0] cfg_init_src_i,
  input wire logic cfg_switch_monitor_i,
  input wire logic pll_locked_i,
  input wire logic osc_fail_i,
  output logic [2:0] active_src_o,
  output logic fail_trap_o,
  output logic irq_o
);
  osc_pkg::osc_bus_req_t bus;
  logic [1:0] pin_sync;
  logic pll_lock_s;
  logic osc_fail_s;
  logic fail_s_q;
  logic [2:0] cur_q;
  logic [2:0] cur_d;
  logic [2:0] req_q;
  logic [2:0] req_d;
  logic lock_q;
  logic lock_d;
  logic fail_q;
  logic fail_d;
  logic swen_q;
  logic swen_d;
  logic [1:0] key_q;
  logic [1:0] key_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic init_q;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] en_q;
  logic [2:0] en_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic init_d;
  logic fail_s_d;
  logic pll_hop;
  logic trap_q;
  logic trap_d;
  logic ctrl_wr;
  logic frozen;
  logic sw_done;
  logic sw_refused;
  logic fail_event;
  logic [2:0] stat_set;

  // reserved code falls back to fast RC
  function automatic logic [2:0] osc_norm(input logic [2:0] code);
    osc_norm = (code == osc_pkg::OSC_SRC_RSVD) ? 3'(osc_pkg::OSC_SRC_FAST_RC) : code; // [RL3]
  endfunction : osc_norm

  function automatic logic osc_is_pll(input logic [2:0] code);
    osc_is_pll = (code == osc_pkg::OSC_SRC_PRI_PLL) || (code == osc_pkg::OSC_SRC_FAST_RC_PLL);
  endfunction : osc_is_pll

  always_comb
  begin
    bus.addr = reg_addr_i;
    bus.wdata = reg_wdata_i;
    bus.wr = reg_wr_i;
    bus.rd = reg_rd_i;
  end

  osc_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({pll_locked_i, osc_fail_i}),
    .sync_o(pin_sync)
  );
  assign pll_lock_s = pin_sync[1];
  assign osc_fail_s = pin_sync[0];
  // edge only, so a stuck failure does not re-trap after software clears the flag
  assign fail_event = osc_fail_s && !fail_s_q;

  // the key must be the access right before the control write; anything else disarms it
  assign ctrl_wr = bus.wr && (bus.addr == `OSC_ADDR_CTRL) && (key_q == 2'h2); // [RL6]
  assign frozen = lock_q && cfg_switch_monitor_i; // [RL4]
  // a pll-to-pll request is dropped at the start and again at the end of the switch,
  // since software may rewrite the requested field while the count runs down
  assign pll_hop = osc_is_pll(osc_norm(req_q)) && osc_is_pll(osc_norm(cur_q))
    && (osc_norm(req_q) != osc_norm(cur_q)); // [RL7]
  assign sw_refused = swen_q && (cnt_q == 16'h0000 || cnt_q == 16'h0001) && pll_hop; // [RL7]
  assign sw_done = swen_q && (cnt_q == 16'h0001) && !pll_hop;

  always_comb
  begin
    key_d = 2'h0;
    if (bus.wr && bus.addr == `OSC_ADDR_KEY)
    begin
      if (bus.wdata == `OSC_KEY1)
        key_d = 2'h1;
      else if (bus.wdata == `OSC_KEY2 && key_q == 2'h1)
        key_d = 2'h2;
    end
    else if (!bus.wr && !bus.rd)
      key_d = key_q;
  end

  always_comb
  begin
    cur_d = cur_q;
    req_d = req_q;
    lock_d = lock_q;
    fail_d = fail_q;
    swen_d = swen_q;
    cnt_d = cnt_q;
    trap_d = 1'b0;
    if (!init_q)
    begin
      req_d = cfg_init_src_i; // [RL2]
      cur_d = osc_norm(cfg_init_src_i); // [RL1]
    end
    if (ctrl_wr)
    begin
      if (!frozen)
      begin
        req_d = bus.wdata[`OSC_REQ_HI:`OSC_REQ_LO]; // [RL2]
        if (bus.wdata[`OSC_SWEN_BIT] && !swen_q)
        begin
          swen_d = 1'b1; // [RL10]
          cnt_d = 16'h0000;
        end
      end
      // lock bit is sticky once set until reset
      lock_d = lock_q | bus.wdata[`OSC_LOCK_BIT];
      if (!bus.wdata[`OSC_FAIL_BIT])
        fail_d = 1'b0; // [RL8]
      else if (!fail_q)
        trap_d = 1'b1; // [RL8]
      if (bus.wdata[`OSC_FAIL_BIT])
        fail_d = 1'b1;
    end
    if (swen_q)
    begin
      if (sw_refused)
      begin
        swen_d = 1'b0; // [RL7]
        cnt_d = 16'h0000;
      end
      else if (cnt_q == 16'h0000)
        cnt_d = SWITCH_CYC;
      else if (sw_done)
      begin
        cur_d = osc_norm(req_q); // [RL10] [RL3]
        swen_d = 1'b0; // [RL10]
        cnt_d = 16'h0000;
      end
      else
        cnt_d = cnt_q - 16'h0001;
    end
    // set wins over a software clear in the same cycle
    if (fail_event)
    begin
      fail_d = 1'b1; // [RL11]
      trap_d = 1'b1; // [RL11]
    end
  end

  assign stat_set = {sw_refused, fail_event || trap_d, sw_done};

  always_comb
  begin
    en_d = en_q;
    stat_d = stat_q;
    if (bus.wr && bus.addr == `OSC_ADDR_IRQ_EN)
      en_d = bus.wdata[2:0];
    if (bus.wr && bus.addr == `OSC_ADDR_IRQ_CLR)
      stat_d = stat_q & ~bus.wdata[2:0];
    stat_d = stat_d | stat_set;
    irq_d = |(stat_d & en_d);
  end

  // init_q marks the single cycle in which the configuration code is loaded
  always_comb
  begin
    init_d = 1'b1;
    fail_s_d = osc_fail_s;
  end

  always_comb
  begin
    rdata_d = 16'h0000; // [RL9]
    if (bus.rd)
    begin
      unique case (bus.addr)
        `OSC_ADDR_CTRL:
        begin
          rdata_d[`OSC_CUR_HI:`OSC_CUR_LO] = cur_q; // [RL1]
          rdata_d[`OSC_REQ_HI:`OSC_REQ_LO] = req_q;
          rdata_d[`OSC_LOCK_BIT] = lock_q;
          rdata_d[`OSC_PLL_LOCK_BIT] = pll_lock_s; // [RL5]
          rdata_d[`OSC_FAIL_BIT] = fail_q;
          rdata_d[`OSC_SWEN_BIT] = swen_q;
        end
        `OSC_ADDR_IRQ_STAT: rdata_d[2:0] = stat_q;
        `OSC_ADDR_IRQ_EN: rdata_d[2:0] = en_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      cur_q <= 3'h0;
      req_q <= 3'h0;
      lock_q <= 1'b0;
      fail_q <= 1'b0;
      swen_q <= 1'b0;
      key_q <= 2'h0;
      cnt_q <= 16'h0000;
      init_q <= 1'b0;
      stat_q <= 3'h0;
      en_q <= 3'h0;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
      trap_q <= 1'b0;
      fail_s_q <= 1'b0;
    end
    else
    begin
      cur_q <= cur_d;
      req_q <= req_d;
      lock_q <= lock_d;
      fail_q <= fail_d;
      swen_q <= swen_d;
      key_q <= key_d;
      cnt_q <= cnt_d;
      init_q <= init_d;
      stat_q <= stat_d;
      en_q <= en_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      trap_q <= trap_d;
      fail_s_q <= fail_s_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign active_src_o = cur_q;
  assign fail_trap_o = trap_q;
  assign irq_o = irq_q;

  a_write_needs_key: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL6]
    (init_q && bus.wr && bus.addr == `OSC_ADDR_CTRL && key_q != 2'h2)
    |=> $stable(req_q)) else $error("control write took effect without unlock");

  a_key_armed: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL6]
    (bus.wr && bus.addr == `OSC_ADDR_KEY && bus.wdata == `OSC_KEY2 && key_q == 2'h1)
    |=> key_q == 2'h2) else $error("second key did not arm the control write");

  a_key_used: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL6]
    ctrl_wr |=> key_q == 2'h0)
    else $error("unlock was not consumed by the control write");

  a_init_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL2] [RL1]
    (!init_q && !ctrl_wr) |=> req_q == $past(cfg_init_src_i)
    && cur_q == osc_norm($past(cfg_init_src_i)))
    else $error("configuration code not loaded after reset");

  a_frozen_req: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL4]
    (init_q && frozen && !swen_q) |=> $stable(req_q) && !$rose(swen_q))
    else $error("locked configuration was modified");

  a_lock_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL4]
    lock_q |=> lock_q)
    else $error("lock bit cleared without reset");

  a_no_pll_hop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL7]
    (init_q && osc_is_pll(cur_q) && $changed(cur_q)) |-> !osc_is_pll($past(cur_q)))
    else $error("direct pll to pll switch happened");

  a_refuse_keeps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL7]
    sw_refused |=> !swen_q && $stable(cur_q))
    else $error("refused switch changed the current source");

  a_no_reserved: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL3] [RL1]
    init_q |-> cur_q != osc_pkg::OSC_SRC_RSVD)
    else $error("current source shows reserved code");

  a_cur_on_done: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL1]
    (init_q && $past(init_q) && $changed(cur_q)) |-> $past(sw_done))
    else $error("current source changed outside a switch");

  a_fail_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL11]
    fail_event |=> fail_q && trap_q)
    else $error("oscillator failure did not set flag and trap");

  a_sw_fail_trap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL8]
    (ctrl_wr && bus.wdata[`OSC_FAIL_BIT] && !fail_q) |=> trap_q && fail_q)
    else $error("software fail write did not trap");

  a_fail_only_sw: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL8]
    $fell(fail_q) |-> $past(ctrl_wr))
    else $error("fail flag cleared without software write");

  a_fail_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL8]
    (fail_q && !ctrl_wr) |=> fail_q)
    else $error("fail flag dropped with no control write");

  a_swen_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL10]
    (ctrl_wr && !frozen && bus.wdata[`OSC_SWEN_BIT] && !swen_q) |=> swen_q)
    else $error("switch enable write did not start a switch");

  a_switch_ends: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL10]
    $rose(swen_q) |-> ##[1:300] !swen_q)
    else $error("switch enable never cleared");

  a_done_updates: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL10]
    sw_done |=> !swen_q && cur_q == osc_norm($past(req_q)))
    else $error("completed switch did not report the new source");

  a_pll_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL5]
    (bus.rd && bus.addr == `OSC_ADDR_CTRL)
    |=> reg_rdata_o[`OSC_PLL_LOCK_BIT] == $past(pll_lock_s))
    else $error("pll lock status misreported");

  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RL9]
    ($past(bus.rd) && $past(bus.addr) == `OSC_ADDR_CTRL)
    |-> (reg_rdata_o & 16'h8856) == 16'h0000)
    else $error("unimplemented bits read non-zero");
endmodule : osc_ctrl
`default_nettype wire

// file: tb/osc_ctrl_tb_top.sv
// self-checking testbench for the oscillator select control block
`default_nettype none
module osc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [2:0] cfg = 3'h4;
  logic mon = 1'b0;
  logic pll = 1'b1;
  logic fail = 1'b0;
  logic [15:0] rdata;
  logic [2:0] active;
  logic trap;
  logic irq;
  logic [15:0] rdq;
  logic lk = 1'b0;
  int failures = 0;
  int check_count = 0;
  int trap_cnt = 0;
  int t0;

  // short switch time keeps the run brief
  osc_ctrl #(.SWITCH_CYC(16'h0002)) u_osc_ctrl (
    .sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .cfg_init_src_i(cfg),
    .cfg_switch_monitor_i(mon), .pll_locked_i(pll), .osc_fail_i(fail),
    .active_src_o(active), .fail_trap_o(trap), .irq_o(irq)
  );

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    if (trap === 1'b1)
      trap_cnt++;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    rdq = rdata;
    @(posedge clk);
  endtask : rd_reg

  task automatic wctl(input logic [15:0] d);
    wr_reg(4'h1, 16'h0055);
    wr_reg(4'h1, 16'h00aa);
    wr_reg(4'h0, d);
  endtask : wctl

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic [2:0] c);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // all unimplemented bits are written as ones and must read back zero
  task automatic sw(input logic [2:0] c, input logic [2:0] e);
    int n;
    n = 0;
    wctl({5'h1f, c, 8'h77});
    rd_reg(4'h0);
    while (rdq[0] !== 1'b0 && n < 20)
    begin
      rd_reg(4'h0);
      n++;
    end
    chk(rdq, {1'b0, e, 1'b0, c, lk, 7'h20});
    chk({13'h0, active}, {13'h0, e});
  endtask : sw

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial
  begin
    do_reset(3'h4);
    rd_reg(4'h0);
    chk(rdq, 16'h0420);
    wr_reg(4'h0, 16'h0101);
    rd_reg(4'h0);
    chk(rdq, 16'h0420);
    rd_reg(4'hf);
    chk(rdq, 16'h0000);
    for (int c = 1; c < 8; c++)
    begin
      sw(3'(c), (c == 4) ? 3'h0 : 3'(c));
      sw(3'h0, 3'h0);
    end
    sw(3'h3, 3'h3);
    sw(3'h1, 3'h3);
    rd_reg(4'h2);
    chk(rdq & 16'h0004, 16'h0004);
    sw(3'h0, 3'h0);
    sw(3'h1, 3'h1);
    sw(3'h3, 3'h1);
    sw(3'h0, 3'h0);
    wr_reg(4'h4, 16'h0007);
    rd_reg(4'h2);
    chk(rdq, 16'h0000);
    wr_reg(4'h3, 16'h0001);
    sw(3'h2, 3'h2);
    settle();
    chk({15'h0, irq}, 16'h0001);
    wr_reg(4'h3, 16'h0000);
    settle();
    chk({15'h0, irq}, 16'h0000);
    wr_reg(4'h3, 16'h0001);
    settle();
    chk({15'h0, irq}, 16'h0001);
    wr_reg(4'h4, 16'h0001);
    settle();
    chk({15'h0, irq}, 16'h0000);
    t0 = trap_cnt;
    wctl(16'h0208);
    settle();
    chk(16'(trap_cnt - t0), 16'h0001);
    rd_reg(4'h2);
    chk(rdq & 16'h0002, 16'h0002);
    repeat (10) @(posedge clk);
    rd_reg(4'h0);
    chk(rdq & 16'h0008, 16'h0008);
    wctl(16'h0200);
    rd_reg(4'h0);
    chk(rdq & 16'h0008, 16'h0000);
    fail <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(4'h0);
    chk(rdq & 16'h0008, 16'h0008);
    chk(16'(trap_cnt - t0), 16'h0002);
    fail <= 1'b0;
    wctl(16'h0200);
    pll <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(4'h0);
    chk(rdq & 16'h0020, 16'h0000);
    pll <= 1'b1;
    repeat (6) @(posedge clk);
    mon <= 1'b1;
    wctl(16'h0280);
    wctl(16'h0581);
    repeat (8) @(posedge clk);
    rd_reg(4'h0);
    chk(rdq & 16'h7781, 16'h2280);
    mon <= 1'b0;
    lk = 1'b1;
    sw(3'h5, 3'h5);
    do_reset(3'h5);
    rd_reg(4'h0);
    chk(rdq, 16'h5520);
    finish_test();
  end
endmodule : osc_ctrl_tb_top
`default_nettype wire
